// *** pmcap_regs.sv ***
`timescale 1ns/1ns
`include "pmcap_cfg.svh"

module pmcap_regs #(
	parameter pmcap_pkg::pmcap_func_e FUNC         = pmcap_pkg::PMCAP_FN_EHCI,
	parameter bit                     HAS_DATA_REG = 1'b0,
	parameter bit                     NEEDS_DSI    = 1'b0,
	parameter logic [2:0]             AUX_CODE     = `PMCAP_AUX_DEFAULT,
	parameter bit                     PMI_NEEDED   = 1'b0
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  CAP_BASE,
	input  wire logic [7:0]  CFG_ADDR,
	input  wire logic        CFG_RD,
	input  wire logic        CFG_WR,
	input  wire logic [3:0]  CFG_BE,
	input  wire logic [31:0] CFG_WDATA,
	output logic      [31:0] CFG_RDATA,
	output logic             CFG_HIT,
	output logic             CFG_ACK,
	output logic      [15:0] CAP_WORD
);

	////////////////////////////////////////////////////////////////
	// Declarations

	pmcap_pkg::pmcap_state_e state_q;
	pmcap_pkg::pmcap_state_e state_d;
	logic [31:0]             rdata_q;
	logic [31:0]             rdata_d;
	logic                    hit_q;
	logic                    hit_d;
	logic                    dsi_q;
	logic                    dsi_d;
	logic                    booted_q;
	logic                    booted_d;
	logic [15:0]             word_q;
	logic [15:0]             word_d;
	pmcap_pkg::pmcap_word_t  cur_word;
	logic [7:0]              lo_addr;
	logic [7:0]              hi_addr;
	logic [31:0]             lane_data;
	logic [3:0]              lane_hit;
	logic                    req;
	logic                    wr_seen;

	////////////////////////////////////////////////////////////////
	// Field composition

	pmcap_word u_word (
		.func         (FUNC),
		.has_data_reg (HAS_DATA_REG),
		.dsi          (dsi_q),
		.aux_req      (AUX_CODE),
		.pmi_req      (PMI_NEEDED),
		.word         (cur_word)
	);

	////////////////////////////////////////////////////////////////
	// Init flag: zero in reset, takes its setting after release

	always_comb begin
		booted_d = 1'b1;
		dsi_d    = dsi_q;
		if (!booted_q) begin
			dsi_d = NEEDS_DSI;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			booted_q <= 1'b0;
			dsi_q    <= 1'b0;
		end else begin
			booted_q <= booted_d;
			dsi_q    <= dsi_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Byte lane decode

	always_comb begin
		lo_addr = CAP_BASE + `PMCAP_REG_OFFSET;
		hi_addr = CAP_BASE + `PMCAP_HI_OFFSET;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
			logic [7:0] lane_addr;
			always_comb begin
				lane_addr = {CFG_ADDR[7:2], 2'(gi)};
				lane_hit[gi] = 1'b0;
				lane_data[gi*8 +: 8] = `PMCAP_BYTE_ZERO;
				if (lane_addr == lo_addr) begin
					lane_hit[gi] = CFG_BE[gi];
					lane_data[gi*8 +: 8] = CFG_BE[gi] ? word_q[7:0] : `PMCAP_BYTE_ZERO;
				end else if (lane_addr == hi_addr) begin
					lane_hit[gi] = CFG_BE[gi];
					lane_data[gi*8 +: 8] = CFG_BE[gi] ? word_q[15:8] : `PMCAP_BYTE_ZERO;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Access sequencer

	always_comb begin
		req     = CFG_RD | CFG_WR;
		wr_seen = CFG_WR & ~CFG_RD & (|CFG_WDATA);
		state_d = state_q;
		rdata_d = rdata_q;
		hit_d   = hit_q;
		word_d  = cur_word;
		case (state_q)
			pmcap_pkg::PMCAP_IDLE: begin
				if (req) begin
					state_d = pmcap_pkg::PMCAP_RESP;
					hit_d   = |lane_hit;
					if (CFG_RD) begin
						rdata_d = lane_data;
					end else begin
						// Write accepted and dropped
						rdata_d = `PMCAP_DWORD_ZERO;
					end
				end
			end
			pmcap_pkg::PMCAP_RESP: begin
				state_d = pmcap_pkg::PMCAP_IDLE;
				rdata_d = wr_seen ? `PMCAP_DWORD_ZERO : rdata_q;
			end
			default: begin
				state_d = pmcap_pkg::PMCAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_q <= pmcap_pkg::PMCAP_IDLE;
			rdata_q <= `PMCAP_DWORD_ZERO;
			hit_q   <= 1'b0;
			word_q  <= `PMCAP_WORD_RESET;
		end else begin
			state_q <= state_d;
			rdata_q <= rdata_d;
			hit_q   <= hit_d;
			word_q  <= word_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		CFG_ACK   = (state_q == pmcap_pkg::PMCAP_RESP);
		CFG_HIT   = CFG_ACK & hit_q;
		CFG_RDATA = rdata_q;
		CAP_WORD  = word_q;
	end

endmodule : pmcap_regs

// *** pmcap_cfg.svh ***
`ifndef PMCAP_CFG_SVH
`define PMCAP_CFG_SVH

// Location of the capabilities word past the capability base
`define PMCAP_REG_OFFSET   8'h02
`define PMCAP_HI_OFFSET    8'h03

// Field positions
`define PMCAP_WAKE_MSB     15
`define PMCAP_WAKE_LSB     11
`define PMCAP_D2_BIT       10
`define PMCAP_D1_BIT       9
`define PMCAP_AUX_MSB      8
`define PMCAP_AUX_LSB      6
`define PMCAP_DSI_BIT      5
`define PMCAP_RSVD_BIT     4
`define PMCAP_PMI_BIT      3
`define PMCAP_VER_MSB      2
`define PMCAP_VER_LSB      0

// Wake field index for the cold sleep state
`define PMCAP_WAKE_COLD    4

// Field values
`define PMCAP_VER_VALUE    3'h2
`define PMCAP_AUX_SELF     3'h0
`define PMCAP_AUX_DEFAULT  3'h2
`define PMCAP_WORD_RESET   16'h0000
`define PMCAP_DWORD_ZERO   32'h00000000
`define PMCAP_BYTE_ZERO    8'h00
`define PMCAP_DEFAULT_BASE 8'h40

`endif

// *** pmcap_pkg.sv ***
package pmcap_pkg;

	typedef enum logic [1:0] {
		PMCAP_FN_OHCI1,
		PMCAP_FN_OHCI2,
		PMCAP_FN_EHCI
	} pmcap_func_e;

	typedef enum {
		PMCAP_IDLE,
		PMCAP_RESP
	} pmcap_state_e;

	typedef logic [15:0] pmcap_word_t;
	typedef logic [7:0]  pmcap_byte_t;

endpackage : pmcap_pkg

// *** pmcap_word.sv ***
`timescale 1ns/1ns
`include "pmcap_cfg.svh"

module pmcap_word (
	input  wire pmcap_pkg::pmcap_func_e func,
	input  wire logic                   has_data_reg,
	input  wire logic                   dsi,
	input  wire logic [2:0]             aux_req,
	input  wire logic                   pmi_req,
	output pmcap_pkg::pmcap_word_t      word
);

	logic       is_ehci;
	logic [4:0] wake;
	logic [2:0] aux;
	logic       wake_needs_bus_clock;

	always_comb begin
		is_ehci = (func == pmcap_pkg::PMCAP_FN_EHCI);
		// Field bit 0..4 = D0, D1, D2, D3hot, D3cold
		wake = {1'b1, 1'b1, is_ehci, 1'b1, is_ehci};
		// Data register or no cold wake forces self-powered code
		if (has_data_reg) begin
			aux = `PMCAP_AUX_SELF;
		end else if (!wake[`PMCAP_WAKE_COLD]) begin
			aux = `PMCAP_AUX_SELF;
		end else begin
			aux = aux_req;
		end
		wake_needs_bus_clock = (wake == 5'h00) ? 1'b0 : pmi_req;
		word = `PMCAP_WORD_RESET;
		word[`PMCAP_WAKE_MSB:`PMCAP_WAKE_LSB] = wake;
		word[`PMCAP_D2_BIT] = is_ehci;
		word[`PMCAP_D1_BIT] = 1'b1;
		word[`PMCAP_AUX_MSB:`PMCAP_AUX_LSB] = aux;
		word[`PMCAP_DSI_BIT] = dsi;
		word[`PMCAP_RSVD_BIT] = 1'b0;
		word[`PMCAP_PMI_BIT] = wake_needs_bus_clock;
		word[`PMCAP_VER_MSB:`PMCAP_VER_LSB] = `PMCAP_VER_VALUE;
	end

endmodule : pmcap_word

// *** pmcap_host.sv ***
`timescale 1ns/1ns
module pmcap_host (
	input  wire logic        SYS_CLK,
	input  wire logic        CFG_ACK,
	input  wire logic        CFG_HIT,
	input  wire logic [31:0] CFG_RDATA,
	output logic      [7:0]  CFG_ADDR,
	output logic             CFG_RD,
	output logic             CFG_WR,
	output logic      [3:0]  CFG_BE,
	output logic      [31:0] CFG_WDATA
);
	initial {CFG_ADDR, CFG_RD, CFG_WR, CFG_BE, CFG_WDATA} = '0;
	// Request held through the ack cycle, then leftovers shown inverted
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
		output logic ack, output logic hit, output logic [31:0] rd);
		@(posedge SYS_CLK) #1;
		{CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = {w, !w, a, b, d};
		@(posedge SYS_CLK) #1;
		// Answer settled and standing until the closing edge
		ack = CFG_ACK;
		hit = CFG_HIT;
		rd  = CFG_RDATA;
		@(posedge SYS_CLK) #1;
		{CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = {2'b00, ~a, ~b, ~d};
	endtask : xfer
endmodule : pmcap_host

// *** pmcap_regs_asserts.sv ***
`timescale 1ns/1ns
module pmcap_regs_asserts (
	input wire logic        SYS_CLK,
	input wire logic        RST,
	input wire logic [7:0]  CAP_BASE,
	input wire logic [7:0]  CFG_ADDR,
	input wire logic        CFG_RD,
	input wire logic        CFG_WR,
	input wire logic [3:0]  CFG_BE,
	input wire logic [31:0] CFG_RDATA,
	input wire logic        CFG_HIT,
	input wire logic        CFG_ACK,
	input wire logic [15:0] CAP_WORD
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	property p_ack; (CFG_RD || CFG_WR) && !CFG_ACK |=> CFG_ACK; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_one; CFG_ACK |=> !CFG_ACK; endproperty
	a_one: assert property (p_one) else $error("ack long");
	property p_why; CFG_ACK |-> $past(CFG_RD || CFG_WR); endproperty
	a_why: assert property (p_why) else $error("stray ack");
	property p_wr; CFG_ACK && $past(CFG_WR) |-> CFG_RDATA == 32'h0; endproperty
	a_wr: assert property (p_wr) else $error("write data");
	property p_ro; CFG_WR && CAP_WORD != 16'h0 |=> $stable(CAP_WORD); endproperty
	a_ro: assert property (p_ro) else $error("word changed");
	property p_ver; CAP_WORD != 16'h0 |-> {CAP_WORD[4], CAP_WORD[2:0]} == 4'h2; endproperty
	a_ver: assert property (p_ver) else $error("version");
	property p_aux; !CAP_WORD[15] |-> CAP_WORD[8:6] == 3'h0; endproperty
	a_aux: assert property (p_aux) else $error("aux");
	property p_pmi; CAP_WORD[15:11] == 5'h0 |-> !CAP_WORD[3]; endproperty
	a_pmi: assert property (p_pmi) else $error("clock bit");
	property p_rd;
		CFG_ACK && $past(CFG_RD && CFG_ADDR == CAP_BASE && CAP_BASE[1:0] == 2'h0 && CFG_BE == 4'hF)
			|-> CFG_HIT && CFG_RDATA[31:16] == CAP_WORD;
	endproperty
	a_rd: assert property (p_rd) else $error("read data");
	c_hit: cover property (CFG_ACK && CFG_HIT);
	c_miss: cover property (CFG_ACK && !CFG_HIT);
	c_wr: cover property (CFG_ACK && $past(CFG_WR));
endmodule : pmcap_regs_asserts
bind pmcap_regs pmcap_regs_asserts u_asserts (.SYS_CLK, .RST, .CAP_BASE, .CFG_ADDR, .CFG_RD, .CFG_WR, .CFG_BE,
	.CFG_RDATA, .CFG_HIT, .CFG_ACK, .CAP_WORD);

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	logic        clk, rst, rq, wq, hit, ack_o, ack, hs, h;
	logic [31:0] model_q[$];
	logic [7:0]  base, ad, a, b;
	logic [3:0]  bq, be;
	logic [15:0] word;
	logic [31:0] wd, rdat, r, e, rd;
	int          seed, n_errors, samples_checked, w;
	pmcap_host u_host (.SYS_CLK(clk), .CFG_ACK(ack_o), .CFG_HIT(hit), .CFG_RDATA(rdat), .CFG_ADDR(ad), .CFG_RD(rq),
		.CFG_WR(wq),
		.CFG_BE(bq), .CFG_WDATA(wd));
	pmcap_regs DUT (.SYS_CLK(clk), .RST(rst), .CAP_BASE(base), .CFG_ADDR(ad), .CFG_RD(rq), .CFG_WR(wq), .CFG_BE(bq),
		.CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_HIT(hit), .CFG_ACK(ack_o), .CAP_WORD(word));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	task automatic do_reset();
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 check(word, 32'h0);
		rst = 1'b0;
		repeat (3) @(posedge clk);
	endtask : do_reset
	initial begin
		#20000 n_errors++;
		close_out();
	end
	initial begin
		seed = 32'h0488C87A;
		base = 8'h40;
		w = 31 << 11 | 3 << 9 | 2 << 6 | 2;
		do_reset();
		$display("reset test done");
		for (int i = 0; i < 60; i++) begin
			if (i == 30)
				do_reset();
			r = $random(seed);
			base = r[2] ? {1'b0, r[30:26], 2'b00} : {1'b0, r[30:24]};
			a = r[0] ? base : r[15:8];
			be = r[3] ? 4'hF : r[23:20];
			u_host.xfer(r[4], a, be, ~r, ack, hs, rd);
			e = 32'h0;
			h = 1'b0;
			for (int k = 0; k < 4; k++) begin
				b = {a[7:2], k[1:0]};
				if (be[k] && (b == base + 8'h02 || b == base + 8'h03)) begin
					h = 1'b1;
					if (!r[4])
						e[8 * k +: 8] = b == base + 8'h02 ? w[7:0] : w[15:8];
				end
			end
			model_q.push_back(e);
			check(ack, 1'b1);
			check(rd, model_q.pop_front());
			check(hs, h);
			check(word, w[15:0]);
		end
		$display("traffic test done");
		close_out();
	end
endmodule : tb_top
